// ---- boundary_scan_tap_core.v ----
// boundary-scan test access port core: controller, instruction and data registers
//
// Functional notes
// RL1: controller follows select at each rising test clock; select high resets within five.
// RL2: inputs sampled on rising test-clock edge, outputs change on falling edge.
// RL3: controller must pass idle after reset before any test operation.
// RL4: boundary-control operation runs only while controller sits in idle.
// RL5: scan-select states do nothing and always leave after one cycle.
// RL6: data capture loads selected register on rising edge leaving capture; the boundary-control chain holds its value instead.
// RL7: shift entry connects register; first falling edge drives its lsb out.
// RL8: one shift per rising edge in shift state, none in entry cycle.
// RL9: first falling edge after first exit state floats serial output.
// RL10: return to shift keeps register; pause states hold contents.
// RL11: data shadow latches load on falling edge after update entry.
// RL12: instruction capture loads 10000001 for path verification.
// RL13: new instruction and mode take effect on falling edge after update.
// RL14: test registers have shift stage plus shadow; bypass, identification shift only.
// RL15: instruction eight bits, bit 7 is even parity over opcode.
// RL16: unimplemented family opcodes behave as bypass.
// RL17: reset state sets instruction to 10000001, identification read.
// RL18: instruction decodes mode, operation, one of four registers, capture source.
// RL19: boundary chain 84 cells: one per control pin, two per bus pin.
// RL20: instruction selects boundary capture source; chain may change in idle.
// RL21: reset sets boundary cells 83 to 80 to one.
// RL22: boundary chain shifts serial input through 83 down to 0.
// RL23: bits 83-72 controls, 71-54 a in, 53-36 a out, 35-18 b in, 17-0 b out.
// RL24: boundary-control chain 21 bits, shifts through 20 down to 0.
// RL25: serial output floats outside the shift states.
// RL26: bypass is one shift stage without shadow, selected by decode.
`timescale 1ns/10ps
`include "scan_tap_regs.vh"
module boundary_scan_tap_core #(
    parameter [31:0] IDENT_CODE = 32'h00000001 // arbitrary identification value
) (
    input  wire                 mclk_i,
    input  wire                 reset_n_i,
    input  wire                 tck_i,
    input  wire                 tms_i,
    input  wire                 tdi_i,
    input  wire [`BCELL_W-1:0]  pin_capture_i,
    output reg                  tdo_o,
    output reg                  tdo_oe_o,
    output reg                  test_mode_o,
    output reg                  highz_mode_o,
    output reg  [`BCELL_W-1:0]  bcell_drive_o,
    output reg  [`BCTRL_W-1:0]  bctrl_drive_o,
    output reg                  run_test_o
);
    // two-flop synchronisers on the link pins
    reg [1:0] tck_s;
    reg [1:0] tms_s;
    reg [1:0] tdi_s;
    reg       tck_d;
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tck_s <= 2'h0;
            tms_s <= 2'h3;
            tdi_s <= 2'h3;
            tck_d <= 1'b0;
        end else begin
            tck_s <= {tck_s[0], tck_i};
            tms_s <= {tms_s[0], tms_i};
            tdi_s <= {tdi_s[0], tdi_i};
            tck_d <= tck_s[1];
        end
    end
    wire tck_rise = tck_s[1] & ~tck_d; // RL2
    wire tck_fall = ~tck_s[1] & tck_d; // RL2
    wire tms      = tms_s[1];
    wire tdi      = tdi_s[1];

    // controller state
    reg  [15:0] state;
    reg  [15:0] next_state;
    always @* begin
        case (state)
            `ST_RESET:    next_state = tms ? `ST_RESET : `ST_IDLE; // RL3
            `ST_IDLE:     next_state = tms ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_DR:   next_state = tms ? `ST_SEL_IR : `ST_CAP_DR; // RL5
            `ST_CAP_DR:   next_state = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
            `ST_SHIFT_DR: next_state = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
            `ST_EXIT1_DR: next_state = tms ? `ST_UPD_DR : `ST_PAUSE_DR;
            `ST_PAUSE_DR: next_state = tms ? `ST_EXIT2_DR : `ST_PAUSE_DR; // RL10
            `ST_EXIT2_DR: next_state = tms ? `ST_UPD_DR : `ST_SHIFT_DR; // RL10
            `ST_UPD_DR:   next_state = tms ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_IR:   next_state = tms ? `ST_RESET : `ST_CAP_IR; // RL5
            `ST_CAP_IR:   next_state = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
            `ST_SHIFT_IR: next_state = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
            `ST_EXIT1_IR: next_state = tms ? `ST_UPD_IR : `ST_PAUSE_IR;
            `ST_PAUSE_IR: next_state = tms ? `ST_EXIT2_IR : `ST_PAUSE_IR; // RL10
            `ST_EXIT2_IR: next_state = tms ? `ST_UPD_IR : `ST_SHIFT_IR; // RL10
            `ST_UPD_IR:   next_state = tms ? `ST_SEL_DR : `ST_IDLE;
            default:      next_state = `ST_RESET;
        endcase
    end

    // advance only on a rising test-clock edge; tms high reaches reset in five
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= `ST_RESET;
        end else if (tck_rise) begin
            state <= next_state; // RL1
        end
    end

    wire in_reset  = (state == `ST_RESET);
    wire in_idle   = (state == `ST_IDLE);
    wire cap_dr    = tck_rise & (state == `ST_CAP_DR); // RL6
    wire cap_ir    = tck_rise & (state == `ST_CAP_IR); // RL12
    wire shf_dr    = tck_rise & (state == `ST_SHIFT_DR); // RL8
    wire shf_ir    = tck_rise & (state == `ST_SHIFT_IR); // RL8
    wire upd_dr    = tck_fall & (state == `ST_UPD_DR); // RL11
    wire upd_ir    = tck_fall & (state == `ST_UPD_IR); // RL13
    wire tlr_fall  = tck_fall & in_reset;

    // instruction register: shift stage and shadow, both reset to zero; 0x81 is forced below
    wire [`IR_W-1:0] ir_shift;
    wire [`IR_W-1:0] ir_cur_raw;
    reg  [`IR_W-1:0] ir_cur;
    scan_chain #(.W(`IR_W), .HAS_SHADOW(1)) u_ir (
        .mclk_i     (mclk_i),
        .reset_n_i  (reset_n_i),
        .tlr_i      (tlr_fall),
        .rst_val_i  (`IR_RESET),
        .capture_i  (cap_ir),
        .cap_data_i (`IR_RESET),
        .shift_i    (shf_ir),
        .sin_i      (tdi),
        .update_i   (upd_ir),
        .shift_q_o  (ir_shift),
        .shadow_o   (ir_cur_raw)
    );
    // shadow flops reset to zero, so reset value is forced here until first update
    reg ir_valid;
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ir_valid <= 1'b0;
        end else if (tlr_fall) begin
            ir_valid <= 1'b0;
        end else if (upd_ir) begin
            ir_valid <= 1'b1;
        end
    end
    always @* begin
        ir_cur = ir_valid ? ir_cur_raw : `IR_RESET; // RL17
    end

    // instruction as it stands after this edge, so the mode moves on the update fall itself
    wire [`IR_W-1:0] ir_next = upd_ir ? ir_shift : ir_cur; // RL13

    // decode: unsupported or bad-parity opcodes fall to bypass, normal mode
    reg [1:0] dr_sel;
    reg       dec_test;
    reg       dec_highz;
    always @* begin
        dr_sel    = `DR_BYPASS; // RL16 RL26
        dec_test  = 1'b0;
        dec_highz = 1'b0;
        case (ir_next) // RL18 RL15
            `OP_EXTEST, `OP_INTEST: begin
                dr_sel   = `DR_BCELL;
                dec_test = 1'b1;
            end
            `OP_IDCODE:  dr_sel = `DR_IDENT;
            `OP_SAMPLE, `OP_READBN, `OP_CELLTST: dr_sel = `DR_BCELL;
            `OP_READBT: begin
                dr_sel   = `DR_BCELL;
                dec_test = 1'b1;
            end
            `OP_HIGHZ:   dec_highz = 1'b1;
            `OP_CLAMP, `OP_BOUNDARY_RUN_TEST_INSTR, `OP_TOPHIP: dec_test = 1'b1;
            `OP_SCANCN:  dr_sel = `DR_BCTRL;
            `OP_SCANCT: begin
                dr_sel   = `DR_BCTRL;
                dec_test = 1'b1;
            end
            default:     dr_sel = `DR_BYPASS;
        endcase
    end

    // boundary cell capture source chosen by instruction
    wire [`BCELL_W-1:0] bc_shift;
    wire [`BCELL_W-1:0] bc_shadow;
    reg  [`BCELL_W-1:0] bc_cap;
    always @* begin
        case (ir_cur) // RL20
            `OP_READBN, `OP_READBT: bc_cap = bc_shift;
            `OP_CELLTST:            bc_cap = ~bc_shift;
            default:                bc_cap = pin_capture_i;
        endcase
    end
    wire [`BCELL_W-1:0] bc_rst = {`BC_OE_RESET, {(`BCELL_W-4){1'b0}}}; // RL21
    // boundary chain, 84 cells, tdi enters at 83 and bit 0 leaves first
    scan_chain #(.W(`BCELL_W), .HAS_SHADOW(1)) u_bcell ( // RL19 RL22 RL23
        .mclk_i     (mclk_i),
        .reset_n_i  (reset_n_i),
        .tlr_i      (tlr_fall),
        .rst_val_i  (bc_rst),
        .capture_i  (cap_dr & (dr_sel == `DR_BCELL)),
        .cap_data_i (bc_cap),
        .shift_i    (shf_dr & (dr_sel == `DR_BCELL)),
        .sin_i      (tdi),
        .update_i   (upd_dr & (dr_sel == `DR_BCELL)),
        .shift_q_o  (bc_shift),
        .shadow_o   (bc_shadow)
    );

    // boundary-control chain, 21 bits, holds its value on capture
    wire [`BCTRL_W-1:0] bt_shift;
    wire [`BCTRL_W-1:0] bt_shadow;
    scan_chain #(.W(`BCTRL_W), .HAS_SHADOW(1)) u_bctrl ( // RL24
        .mclk_i     (mclk_i),
        .reset_n_i  (reset_n_i),
        .tlr_i      (1'b0),
        .rst_val_i  ({`BCTRL_W{1'b0}}),
        .capture_i  (1'b0),
        .cap_data_i (bt_shift),
        .shift_i    (shf_dr & (dr_sel == `DR_BCTRL)),
        .sin_i      (tdi),
        .update_i   (upd_dr & (dr_sel == `DR_BCTRL)),
        .shift_q_o  (bt_shift),
        .shadow_o   (bt_shadow)
    );

    // bypass and identification: shift stage only, no shadow
    reg                bypass_q;
    reg [`IDR_W-1:0]   ident_q;
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bypass_q <= 1'b0;
            ident_q  <= {`IDR_W{1'b0}};
        end else begin
            if (cap_dr & (dr_sel == `DR_BYPASS)) begin
                bypass_q <= 1'b0; // RL26 RL14
            end else if (shf_dr & (dr_sel == `DR_BYPASS)) begin
                bypass_q <= tdi;
            end
            if (cap_dr & (dr_sel == `DR_IDENT)) begin
                ident_q <= IDENT_CODE; // RL14
            end else if (shf_dr & (dr_sel == `DR_IDENT)) begin
                ident_q <= {tdi, ident_q[`IDR_W-1:1]};
            end
        end
    end

    // serial output mux, lsb of the selected register
    reg sel_lsb;
    always @* begin
        case (dr_sel)
            `DR_BCELL: sel_lsb = bc_shift[0];
            `DR_BCTRL: sel_lsb = bt_shift[0];
            `DR_IDENT: sel_lsb = ident_q[0];
            default:   sel_lsb = bypass_q;
        endcase
    end

    // outputs change only on falling edges; floats outside shift states
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (tck_fall) begin
            if (state == `ST_SHIFT_DR) begin
                tdo_o    <= sel_lsb; // RL7
                tdo_oe_o <= 1'b1; // RL7
            end else if (state == `ST_SHIFT_IR) begin
                tdo_o    <= ir_shift[0]; // RL7
                tdo_oe_o <= 1'b1;
            end else begin
                tdo_oe_o <= 1'b0; // RL9 RL25
            end
        end
    end

    // mode and drive outputs, updated on falling edges (RL13 RL2)
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            test_mode_o   <= 1'b0;
            highz_mode_o  <= 1'b0;
            bcell_drive_o <= {`BC_OE_RESET, {(`BCELL_W-4){1'b0}}};
            bctrl_drive_o <= {`BCTRL_W{1'b0}};
            run_test_o    <= 1'b0;
        end else if (tck_fall) begin
            test_mode_o   <= dec_test & ~in_reset; // RL13
            highz_mode_o  <= dec_highz & ~in_reset;
            // follow the latch on the fall that loads it, not one test clock later
            bcell_drive_o <= in_reset ? bc_rst :
                             (upd_dr & (dr_sel == `DR_BCELL)) ? bc_shift : bc_shadow; // RL11 RL21
            bctrl_drive_o <= (upd_dr & (dr_sel == `DR_BCTRL)) ? bt_shift : bt_shadow; // RL11
            run_test_o    <= in_idle & (ir_cur == `OP_BOUNDARY_RUN_TEST_INSTR); // RL4
        end
    end
endmodule // boundary_scan_tap_core

// ---- scan_chain.v ----
// generic shift stage with optional parallel capture and shadow latch
`timescale 1ns/10ps
module scan_chain #(
    parameter W          = 8,
    parameter HAS_SHADOW = 1
) (
    input  wire         mclk_i,
    input  wire         reset_n_i,
    input  wire         tlr_i,
    input  wire [W-1:0] rst_val_i,
    input  wire         capture_i,
    input  wire [W-1:0] cap_data_i,
    input  wire         shift_i,
    input  wire         sin_i,
    input  wire         update_i,
    output reg  [W-1:0] shift_q_o,
    output reg  [W-1:0] shadow_o
);
    // shift stage: capture or shift on rising test-clock edge, lsb leaves first
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shift_q_o <= {W{1'b0}};
        end else if (capture_i) begin
            shift_q_o <= cap_data_i;
        end else if (shift_i) begin
            shift_q_o <= {sin_i, shift_q_o[W-1:1]};
        end
    end

    // shadow latch, loaded on the falling edge in update (RL14)
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shadow_o <= {W{1'b0}};
        end else if (HAS_SHADOW == 0) begin
            shadow_o <= {W{1'b0}};
        end else if (tlr_i) begin
            shadow_o <= rst_val_i;
        end else if (update_i) begin
            shadow_o <= shift_q_o;
        end
    end
endmodule // scan_chain

// ---- scan_host_model.sv ----
// four-wire test controller model on the far side of the scan port
`timescale 1ns/10ps
module scan_host_model (
    input  wire logic mclk_i,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i,
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o
);
    // clock stands still low between frames; select and data rest at pull-up level
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end
    // one test cycle; output taken late in the high phase, well after it settled
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        @(posedge mclk_i);
        tms_o <= tms;
        tdi_o <= tdi;
        // four system clocks low, four high: an 800 ns test clock
        repeat (3) @(posedge mclk_i);
        tck_o <= 1'b1;
        repeat (4) @(posedge mclk_i);
        tdo = tdo_oe_i ? tdo_i : 1'bz;
        tck_o <= 1'b0;
    endtask
    // five cycles with select high, then through idle before any operation
    task automatic reset_tap;
        logic d;
        repeat (5) step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
    endtask
    // idle to idle scan, lsb first; brk parks in pause twice and resumes shifting
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        input int brk, output logic [127:0] dout);
        logic d;
        dout = 128'h0;
        step(1'b1, 1'b1, d);
        if (ir) step(1'b1, 1'b1, d);
        repeat (2) step(1'b0, 1'b1, d);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1 || i == brk, din[i], dout[i]);
            if (i == brk && i != n - 1) begin
                repeat (2) step(1'b0, 1'b1, d);
                step(1'b1, 1'b1, d);
                step(1'b0, 1'b1, d);
            end
        end
        step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
    endtask
endmodule // scan_host_model

// ---- scan_tap_monitor.sv ----
// shadow controller and concurrent checks on the scan port core
`timescale 1ns/10ps
`include "scan_tap_regs.vh"
module scan_tap_monitor (
    input wire                mclk_i,
    input wire                reset_n_i,
    input wire                tck_i,
    input wire                tms_i,
    input wire                tdi_i,
    input wire [`BCELL_W-1:0] pin_capture_i,
    input wire                tdo_o,
    input wire                tdo_oe_o,
    input wire                test_mode_o,
    input wire                highz_mode_o,
    input wire [`BCELL_W-1:0] bcell_drive_o,
    input wire [`BCTRL_W-1:0] bctrl_drive_o,
    input wire                run_test_o
);
    // next state index per state, one nibble each, for select high and low
    localparam [63:0] NEXT_HI = 64'h2FEFCC0287855920;
    localparam [63:0] NEXT_LO = 64'h1BDDBBA146644311;
    reg [3:0] st;
    reg [3:0] st_fall;
    reg [3:0] fall_cnt;
    reg       tck_q;
    reg [3:0] st_out;
    // runs on the raw pin, ahead of the synchronised core, so checks key off the last fall
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st       <= 4'h0;
            st_fall  <= 4'h0;
            fall_cnt <= 4'hF;
            tck_q    <= 1'b0;
            st_out   <= 4'h0;
        end else begin
            tck_q <= tck_i;
            // state behind the core's outputs: they move on the edge where the count leaves 1
            if (fall_cnt == 4'h1) begin
                st_out <= st_fall;
            end
            if (!tck_q && tck_i) begin
                st <= tms_i ? NEXT_HI[{st, 2'b00} +: 4] : NEXT_LO[{st, 2'b00} +: 4];
            end
            if (tck_q && !tck_i) begin
                st_fall  <= st;
                fall_cnt <= 4'h0;
            end else if (fall_cnt != 4'hF) begin
                fall_cnt <= fall_cnt + 4'h1;
            end
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    property p_oe_shift; fall_cnt == 4'h6 |-> tdo_oe_o == (st_fall == 4'h4 || st_fall == 4'hB);
    endproperty
    a_oe_shift: assert property (p_oe_shift) else $error("enable wrong after fall");
    property p_out_fall; $changed(tdo_o) || $changed(tdo_oe_o) |-> fall_cnt inside {[1:6]};
    endproperty
    a_out_fall: assert property (p_out_fall) else $error("serial out moved off fall");
    property p_reset_st; st_fall == 4'h0 && fall_cnt == 4'h6 |-> !test_mode_o && !run_test_o
        && !highz_mode_o && bcell_drive_o[`BC_CTRL_HI:`BC_OE_LO] == `BC_OE_RESET;
    endproperty
    a_reset_st: assert property (p_reset_st) else $error("reset state outputs");
    property p_mode_upd; $changed(test_mode_o) |-> st == 4'h0 || st_fall == 4'hF && fall_cnt < 4'h7;
    endproperty
    a_mode_upd: assert property (p_mode_upd) else $error("mode moved off update");
    property p_highz; $changed(highz_mode_o) |-> st == 4'h0 || st_fall == 4'hF && fall_cnt < 4'h7;
    endproperty
    a_highz: assert property (p_highz) else $error("highz moved off update");
    property p_bcell; $changed(bcell_drive_o) |-> st == 4'h0 || st_fall == 4'h8 || st_fall == 4'h1;
    endproperty
    a_bcell: assert property (p_bcell) else $error("boundary shadow moved");
    property p_bctrl; $changed(bctrl_drive_o) |-> st_fall == 4'h8 && fall_cnt inside {[1:6]};
    endproperty
    a_bctrl: assert property (p_bctrl) else $error("control shadow moved");
    property p_run; run_test_o |-> test_mode_o && st_out == 4'h1;
    endproperty
    a_run: assert property (p_run) else $error("run flag outside idle");
endmodule // scan_tap_monitor
bind boundary_scan_tap_core scan_tap_monitor mon_u (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
    .pin_capture_i(pin_capture_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .test_mode_o(test_mode_o),
    .highz_mode_o(highz_mode_o), .bcell_drive_o(bcell_drive_o),
    .bctrl_drive_o(bctrl_drive_o), .run_test_o(run_test_o)
);

// ---- scan_tap_regs.vh ----
// constants for the boundary-scan test access port core
`ifndef SCAN_TAP_REGS_VH
`define SCAN_TAP_REGS_VH
// controller states, one-hot
`define ST_RESET       16'h0001
`define ST_IDLE        16'h0002
`define ST_SEL_DR      16'h0004
`define ST_CAP_DR      16'h0008
`define ST_SHIFT_DR    16'h0010
`define ST_EXIT1_DR    16'h0020
`define ST_PAUSE_DR    16'h0040
`define ST_EXIT2_DR    16'h0080
`define ST_UPD_DR      16'h0100
`define ST_SEL_IR      16'h0200
`define ST_CAP_IR      16'h0400
`define ST_SHIFT_IR    16'h0800
`define ST_EXIT1_IR    16'h1000
`define ST_PAUSE_IR    16'h2000
`define ST_EXIT2_IR    16'h4000
`define ST_UPD_IR      16'h8000
// register widths
`define IR_W           8
`define BCELL_W        84
`define BCTRL_W        21
`define IDR_W          32
// instruction register capture and reset value
`define IR_RESET       8'h81
`define IR_PARITY_BIT  7
// opcodes
`define OP_EXTEST      8'h00
`define OP_IDCODE      8'h81
`define OP_SAMPLE      8'h82
`define OP_INTEST      8'h03
`define OP_HIGHZ       8'h06
`define OP_CLAMP       8'h87
`define OP_BOUNDARY_RUN_TEST_INSTR        8'h09
`define OP_READBN      8'h0A
`define OP_READBT      8'h8B
`define OP_CELLTST     8'h0C
`define OP_TOPHIP      8'h8D
`define OP_SCANCN      8'h8E
`define OP_SCANCT      8'h0F
// data register selects
`define DR_BYPASS      2'h0
`define DR_BCELL       2'h1
`define DR_BCTRL       2'h2
`define DR_IDENT       2'h3
// boundary cell field positions
`define BC_CTRL_HI     83
`define BC_OE_LO       80
`define BC_CTRL_LO     72
`define BC_AIN_LO      54
`define BC_AOUT_LO     36
`define BC_BIN_LO      18
`define BC_BOUT_LO     0
`define BC_OE_RESET    4'hF
// boundary-control opcode field
`define BCTRL_OP_HI    2
`endif

// ---- tb.sv ----
// self-checking bench for the scan port core through the controller model
`timescale 1ns/10ps
module tb;
    localparam [31:0] IDENT_VAL = 32'h00005A5B; // arbitrary identification value
    logic         mclk_i, reset_n_i, tck_i, tms_i, tdi_i;
    logic         tdo_o, tdo_oe_o, test_mode_o, highz_mode_o, run_test_o;
    logic [83:0]  pin_capture_i, bcell_drive_o;
    logic [20:0]  bctrl_drive_o;
    logic [127:0] got;
    logic [127:0] pat = 128'h9E3779B97F4A7C15F39CC0605CEDC834;
    logic [7:0]   ops [15] = '{8'h00, 8'h82, 8'h03, 8'h06, 8'h87, 8'h0A, 8'h8B, 8'h0C,
                               8'h8D, 8'h8E, 8'h0F, 8'h81, 8'h01, 8'h84, 8'h09};
    int           failures = 0;
    int           compares = 0;
    int           cycles = 0;
    int           len;
    boundary_scan_tap_core #(.IDENT_CODE(IDENT_VAL)) dut_u (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
        .pin_capture_i(pin_capture_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
        .test_mode_o(test_mode_o), .highz_mode_o(highz_mode_o),
        .bcell_drive_o(bcell_drive_o), .bctrl_drive_o(bctrl_drive_o), .run_test_o(run_test_o)
    );
    scan_host_model host_u (
        .mclk_i(mclk_i), .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o),
        .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i)
    );
    // path length per opcode; anything unlisted or with bad parity falls back to bypass
    function automatic int dr_len(input logic [7:0] op);
        case (op)
            8'h00, 8'h82, 8'h03, 8'h0A, 8'h8B, 8'h0C: return 84;
            8'h81: return 32;
            8'h8E, 8'h0F: return 21;
            default: return 1;
        endcase
    endfunction
    task automatic check(input logic ok, input string what);
        compares++;
        if (ok !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic wrap_up;
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    // hang guard, well above the roughly 19000 cycles the sequence needs
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        reset_n_i = 1'b0;
        pin_capture_i = 84'h9123456789ABCDEF01357;
        repeat (6) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        check(tdo_oe_o === 1'b0 && test_mode_o === 1'b0, "outputs after reset");
        check(bcell_drive_o[83:80] === 4'hF, "enable cells after reset");
        host_u.reset_tap();
        foreach (ops[k]) begin
            host_u.scan(1'b1, 8, {120'h0, ops[k]}, k == 0 ? 3 : -1, got);
            check(got[7:0] === 8'h81, "instruction capture");
            check(highz_mode_o === (ops[k] === 8'h06), "highz mode");
            if (ops[k] !== 8'h06) check(test_mode_o === (ops[k] inside
                {8'h00, 8'h03, 8'h87, 8'h09, 8'h8B, 8'h8D, 8'h0F}), "mode");
            len = dr_len(ops[k]);
            host_u.scan(1'b0, 128, pat, k == 1 ? 40 : -1, got);
            check((got >> len) === ((pat << len) >> len), "path length");
            if (len == 1) check(got[0] === 1'b0, "bypass capture");
            if (len == 32) check(got[31:0] === IDENT_VAL, "identification");
            if (len == 84) check(bcell_drive_o === pat[127:44], "boundary shadow");
            if (len == 21) check(bctrl_drive_o === pat[127:107], "control shadow");
            if (ops[k] inside {8'h00, 8'h82, 8'h03})
                check(got[83:0] === pin_capture_i, "pin capture");
        end
        repeat (4) @(posedge mclk_i);
        check(run_test_o === 1'b1, "run flag in idle");
        host_u.reset_tap();
        check(run_test_o === 1'b0 && test_mode_o === 1'b0, "test reset modes");
        check(bcell_drive_o[83:80] === 4'hF, "test reset enables");
        host_u.scan(1'b0, 128, pat, -1, got);
        check(got[31:0] === IDENT_VAL, "instruction after test reset");
        wrap_up();
    end
endmodule // tb
